// File: src/icp_timer.sv
// What this block does
// - start masks first count clock, output inactive
// - running duty writes buffered, moved after three
// - cycle match clears, output active, interrupt
// - duty match drives inactive, no clear
// - disable restores interrupt and output defaults
// - carrier unit: low then high width
// - output low, high, or carrier per bits
// - buffered enable writable, active enable read-only
// - companion interrupt resynchronised as transfer strobe
// - transfer on second count clock after strobe
// - carrier compares alternate, each match interrupts
// - carrier reaches pin from first low after active set to first low after clear
// - carrier period N+M+2, high M+1
// - disabling ends a carrier high phase at once
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "icp_map.svh"

module icp_timer #(
  parameter bit CARRIER_UNIT = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic count_tick_in,
  input wire logic companion_irq_in,
  output logic timer_output_out,
  output logic timer_match_irq_out
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    if (ADDR_W < 4 || ADDR_W > 12) begin : g_bad_addr
      $error("icp_timer: ADDR_W must lie between 4 and 12");
    end
    if (`ICP_XFER_TICKS == 0 || `ICP_AGE_MIN == 0) begin : g_bad_map
      $error("icp_timer: timing counts must be nonzero");
    end
  endgenerate

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  icp_pkg::icp_state_t st_ff;
  icp_pkg::icp_state_t nxt_st;
  icp_pkg::icp_apb_t bus;
  logic synced_transfer_strobe;
  logic transfer_pulse;
  logic bus_done;
  logic wr_ctrl;
  logic wr_cmp0;
  logic wr_cmp1;
  logic carrier_mode;
  logic running;
  logic [7:0] cmp_cur;
  logic hit;

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] off);
    addr_is = (a[11:2] == off[11:2]);
  endfunction

  // word index of a register offset, for the read decode
  function automatic logic [9:0] word_idx(input logic [11:0] off);
    word_idx = off[11:2];
  endfunction

  // ---------------------------------------------------------------
  // strobe resynchroniser
  // ---------------------------------------------------------------
  icp_strobe_sync u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .companion_irq_in(companion_irq_in),
    .count_tick_in(count_tick_in),
    .synced_transfer_strobe_out(synced_transfer_strobe),
    .transfer_pulse_out(transfer_pulse)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  always_comb begin
    bus.psel = psel_in;
    bus.penable = penable_in;
    bus.pwrite = pwrite_in;
    bus.paddr = 12'(paddr_in);
    bus.pwdata = pwdata_in;
  end

  assign bus_done = bus.psel & bus.penable & st_ff.pready;
  assign wr_ctrl = bus_done & bus.pwrite &
                   addr_is(bus.paddr, `ICP_OFF_CTRL);
  assign wr_cmp0 = bus_done & bus.pwrite &
                   addr_is(bus.paddr, `ICP_OFF_CMP0);
  assign wr_cmp1 = bus_done & bus.pwrite &
                   addr_is(bus.paddr, `ICP_OFF_CMP1);
  // carrier only on the carrier unit
  assign carrier_mode = st_ff.mode & CARRIER_UNIT;
  assign running = (st_ff.phase != icp_pkg::ICP_IDLE);
  // low width first, then high width
  assign cmp_cur = st_ff.sel ? st_ff.cmp1 : st_ff.cmp0;
  assign hit = (st_ff.cnt == cmp_cur);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // -------------------------------------------------------------
    // register read
    // -------------------------------------------------------------
    // answer is registered so the read mux never sits in a bus path
    // apb slave: one wait state, registered answer
    nxt_st.pready = bus.psel & bus.penable & ~st_ff.pready;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata = `ICP_RST_WORD;
    if (bus.psel & bus.penable & ~st_ff.pready) begin
      case (bus.paddr[11:2])
        word_idx(`ICP_OFF_CTRL): begin
          nxt_st.prdata[`ICP_B_EN] = st_ff.en;
          nxt_st.prdata[`ICP_B_MODE] = st_ff.mode;
          nxt_st.prdata[`ICP_B_RMT] = st_ff.remote;
          nxt_st.prdata[`ICP_B_NRZB] = st_ff.nrzb;
          nxt_st.prdata[`ICP_B_NRZ] = st_ff.nrz;
        end
        word_idx(`ICP_OFF_CMP0): begin
          nxt_st.prdata[7:0] = st_ff.cmp0;
        end
        word_idx(`ICP_OFF_CMP1): begin
          nxt_st.prdata[7:0] = st_ff.pend ? st_ff.cmp1_buf : st_ff.cmp1;
        end
        word_idx(`ICP_OFF_STAT): begin
          nxt_st.prdata[7:0] = st_ff.cnt;
          nxt_st.prdata[`ICP_B_SEL] = st_ff.sel;
          nxt_st.prdata[`ICP_B_CAR] = st_ff.carrier;
          nxt_st.prdata[`ICP_B_OUT] = st_ff.out;
        end
        default: begin
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end

    // -------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------
    // control register
    if (wr_ctrl) begin
      nxt_st.en = bus.pwdata[`ICP_B_EN];
      nxt_st.mode = bus.pwdata[`ICP_B_MODE];
      nxt_st.remote = bus.pwdata[`ICP_B_RMT];
      // only the buffered enable is writable
      nxt_st.nrzb = bus.pwdata[`ICP_B_NRZB];
    end
    if (wr_cmp0) begin
      nxt_st.cmp0 = bus.pwdata[7:0];
    end

    // -------------------------------------------------------------
    // duty and high width buffer
    // -------------------------------------------------------------
    // age saturates so a long wait never wraps back to too young
    // buffer a running duty or high width write
    if (count_tick_in && st_ff.pend && st_ff.age != `ICP_AGE_MIN) begin
      nxt_st.age = st_ff.age + 2'h1;
    end
    if (wr_cmp1) begin
      if (running) begin
        nxt_st.cmp1_buf = bus.pwdata[7:0];
        nxt_st.pend = 1'b1;
        nxt_st.age = 2'h0;
      end else begin
        nxt_st.cmp1 = bus.pwdata[7:0];
        nxt_st.cmp1_buf = bus.pwdata[7:0];
        nxt_st.pend = 1'b0;
      end
    end

    // -------------------------------------------------------------
    // enable transfer
    // -------------------------------------------------------------
    // master bit loaded from slave bit
    if (transfer_pulse & carrier_mode & running) begin
      nxt_st.nrz = st_ff.nrzb;
    end

    // -------------------------------------------------------------
    // count engine
    // -------------------------------------------------------------
    nxt_st.irq = st_ff.irq;
    case (st_ff.phase)
      icp_pkg::ICP_IDLE: begin
        nxt_st.cnt = `ICP_RST_CNT;
        nxt_st.sel = 1'b0;
        nxt_st.carrier = 1'b0;
        nxt_st.irq = 1'b0;
        if (st_ff.en) begin
          nxt_st.phase = icp_pkg::ICP_MASK;
        end
      end
      icp_pkg::ICP_MASK: begin
        if (count_tick_in) begin
          nxt_st.phase = icp_pkg::ICP_RUN;
        end
      end
      icp_pkg::ICP_RUN: begin
        if (count_tick_in) begin
          nxt_st.irq = 1'b0;
          nxt_st.cnt = st_ff.cnt + 8'h01;
          if (hit) begin
            nxt_st.sel = ~st_ff.sel;
            if (carrier_mode) begin
              nxt_st.cnt = `ICP_RST_CNT;
              nxt_st.irq = 1'b1;
              // toggle gives N+1 low, M+1 high
              nxt_st.carrier = ~st_ff.carrier;
            end else if (!st_ff.sel) begin
              nxt_st.cnt = `ICP_RST_CNT;
              nxt_st.irq = 1'b1;
            end
            // transfer only at old value match
            if (st_ff.sel && st_ff.pend && !wr_cmp1 &&
                st_ff.age == `ICP_AGE_MIN) begin
              nxt_st.cmp1 = st_ff.cmp1_buf;
              nxt_st.pend = 1'b0;
            end
          end
        end
      end
      default: begin
        nxt_st.phase = icp_pkg::ICP_IDLE;
      end
    endcase

    // -------------------------------------------------------------
    // stop
    // -------------------------------------------------------------
    // stop restores defaults at once
    if (!st_ff.en) begin
      nxt_st.phase = icp_pkg::ICP_IDLE;
      nxt_st.irq = 1'b0;
      nxt_st.cnt = `ICP_RST_CNT;
      nxt_st.sel = 1'b0;
      nxt_st.carrier = 1'b0;
      nxt_st.nrz = 1'b0;
    end

    // -------------------------------------------------------------
    // carrier gate
    // -------------------------------------------------------------
    // gate moves only while carrier is low, so no runt pulses
    // gate opens on low carrier, closes only when low
    if (nxt_st.nrz) begin
      nxt_st.gate = st_ff.gate | ~nxt_st.carrier;
    end else begin
      nxt_st.gate = st_ff.gate & nxt_st.carrier;
    end

    // -------------------------------------------------------------
    // output pin
    // -------------------------------------------------------------
    if (carrier_mode) begin
      if (!nxt_st.remote) begin
        nxt_st.out = nxt_st.nrz;
      end else begin
        // carrier passes only through open gate
        nxt_st.out = nxt_st.gate & nxt_st.carrier;
      end
    end else if (nxt_st.phase != icp_pkg::ICP_RUN) begin
      nxt_st.out = 1'b0;
    end else if (st_ff.phase == icp_pkg::ICP_RUN && count_tick_in &&
                 hit) begin
      // active at cycle match, inactive at duty
      nxt_st.out = ~st_ff.sel;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= '{
        phase: icp_pkg::ICP_IDLE,
        cnt: `ICP_RST_CNT,
        cmp0: `ICP_RST_CMP,
        cmp1: `ICP_RST_CMP,
        cmp1_buf: `ICP_RST_CMP,
        prdata: `ICP_RST_WORD,
        default: '0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_out = st_ff.prdata;
  assign pready_out = st_ff.pready;
  assign pslverr_out = st_ff.pslverr;
  assign timer_output_out = st_ff.out;
  assign timer_match_irq_out = st_ff.irq;

endmodule // icp_timer

// File: src/icp_map.svh
`ifndef ICP_MAP_SVH
`define ICP_MAP_SVH

// register byte offsets
`define ICP_OFF_CTRL 12'h000
`define ICP_OFF_CMP0 12'h004
`define ICP_OFF_CMP1 12'h008
`define ICP_OFF_STAT 12'h00C

// control register bit positions
`define ICP_B_EN 0
`define ICP_B_MODE 1
`define ICP_B_RMT 2
`define ICP_B_NRZB 3
`define ICP_B_NRZ 4

// status register bit positions
`define ICP_B_SEL 8
`define ICP_B_CAR 9
`define ICP_B_OUT 10

// reset values
`define ICP_RST_CMP 8'h00
`define ICP_RST_CNT 8'h00
`define ICP_RST_WORD 32'h0000_0000

// timing counts in count clocks
`define ICP_AGE_MIN 2'h3
`define ICP_XFER_TICKS 2'h2

`endif

// File: src/icp_pkg.sv
package icp_pkg;

  typedef enum logic [1:0] {
    ICP_IDLE,
    ICP_MASK,
    ICP_RUN
  } icp_phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } icp_apb_t;

  typedef struct packed {
    icp_phase_t phase;
    logic [7:0] cnt;
    logic sel;
    logic carrier;
    logic gate;
    logic out;
    logic irq;
    logic [7:0] cmp0;
    logic [7:0] cmp1;
    logic [7:0] cmp1_buf;
    logic pend;
    logic [1:0] age;
    logic en;
    logic mode;
    logic remote;
    logic nrzb;
    logic nrz;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } icp_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pend;
    logic strobe;
    logic [1:0] tcnt;
    logic xfer;
  } icp_sync_t;

endpackage

// File: src/icp_strobe_sync.sv
`timescale 1ns/1ps
`include "icp_map.svh"

module icp_strobe_sync (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic companion_irq_in,
  input wire logic count_tick_in,
  output logic synced_transfer_strobe_out,
  output logic transfer_pulse_out
);

  icp_pkg::icp_sync_t st_ff;
  icp_pkg::icp_sync_t nxt_st;
  logic edge_seen;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = companion_irq_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.xfer = 1'b0;
    edge_seen = st_ff.s2 & ~st_ff.s3;
    if (count_tick_in) begin
      nxt_st.strobe = st_ff.pend | edge_seen;
      nxt_st.pend = 1'b0;
      if (st_ff.pend | edge_seen) begin
        nxt_st.tcnt = 2'h1;
      end else if (st_ff.tcnt == `ICP_XFER_TICKS) begin
        nxt_st.xfer = 1'b1;
        nxt_st.tcnt = 2'h0;
      end else if (st_ff.tcnt != 2'h0) begin
        nxt_st.tcnt = st_ff.tcnt + 2'h1;
      end
    end else if (edge_seen) begin
      nxt_st.pend = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign synced_transfer_strobe_out = st_ff.strobe;
  assign transfer_pulse_out = st_ff.xfer;

endmodule // icp_strobe_sync

// File: tb/icp_timer_asserts.sv
`timescale 1ns/1ps
`include "icp_map.svh"

module icp_timer_asserts #(
  parameter bit CARRIER_UNIT = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic count_tick_in,
  input wire logic timer_output_out,
  input wire logic timer_match_irq_out
);
  // ------------------------------
  // shadow of control and duty
  // ------------------------------
  logic en_ff, mode_ff, rmt_ff;
  logic [7:0] duty_ff;
  logic [8:0] hi_ff;
  wire logic out = timer_output_out;
  wire logic irq = timer_match_irq_out;
  wire logic wr = psel_in & penable_in & pready_out & pwrite_in;
  wire logic wc = wr & (paddr_in == ADDR_W'(`ICP_OFF_CTRL));
  wire logic wd = wr & (paddr_in == ADDR_W'(`ICP_OFF_CMP1));
  wire logic pwm = en_ff & ~mode_ff;
  wire logic car = en_ff & mode_ff & rmt_ff;

  // high-phase length in count ticks
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_ff <= 1'b0;
      mode_ff <= 1'b0;
      rmt_ff <= 1'b0;
      duty_ff <= 8'h00;
      hi_ff <= 9'h000;
    end else begin
      if (wc) begin
        en_ff <= pwdata_in[`ICP_B_EN];
        mode_ff <= pwdata_in[`ICP_B_MODE] & CARRIER_UNIT;
        rmt_ff <= pwdata_in[`ICP_B_RMT];
      end
      if (wd) begin
        duty_ff <= pwdata_in[7:0];
      end
      if (count_tick_in) begin
        hi_ff <= out ? hi_ff + 9'h001 : 9'h000;
      end
    end
  end

  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  a_irq_on_tick: assert property (
    $rose(irq) |-> $past(count_tick_in)
  ) else $error("irq rose without a count tick");
  a_pwm_rise_irq: assert property (
    pwm && $rose(out) |-> irq
  ) else $error("pwm active edge without irq");
  a_duty_fall_quiet: assert property (
    pwm && $fell(out) |-> !irq
  ) else $error("duty match raised irq");
  a_stop_quiet: assert property (
    wc && !pwdata_in[`ICP_B_EN] |-> ##2 (!irq && !out)
  ) else $error("stop left irq or output set");
  a_car_edge_irq: assert property (
    car && $rose(out) |-> irq
  ) else $error("carrier edge without irq");
  a_high_width: assert property (
    car && $fell(out) |-> hi_ff == {1'b0, duty_ff} + 9'h001
  ) else $error("carrier high phase has wrong width");
  a_one_wait: assert property (
    psel_in && penable_in && !pready_out |=> pready_out
  ) else $error("apb answer not after one wait");
  a_ready_once: assert property (
    pready_out |=> !pready_out && prdata_out == 32'h0000_0000
  ) else $error("apb answer held too long");
endmodule // icp_timer_asserts

bind icp_timer icp_timer_asserts #(
  .CARRIER_UNIT(CARRIER_UNIT),
  .ADDR_W(ADDR_W)
) u_asserts (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .count_tick_in(count_tick_in),
  .timer_output_out(timer_output_out),
  .timer_match_irq_out(timer_match_irq_out)
);

// File: tb/icp_companion.sv
`timescale 1ns/1ps

module icp_companion #(
  parameter int DIV = 8,
  parameter int PERIOD = 4
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic tick_in,
  input wire logic enable_in,
  output logic irq_out
);
  logic [3:0] pre_ff;
  logic [7:0] cnt_ff;
  wire logic wrap = pre_ff == 4'(DIV - 1);
  wire logic last = cnt_ff == 8'(PERIOD - 1);

  // own clock is DIV ticks, idle until enabled
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_ff <= 4'h0;
      cnt_ff <= 8'h00;
      irq_out <= 1'b0;
    end else if (!enable_in) begin
      pre_ff <= 4'h0;
      cnt_ff <= 8'h00;
      irq_out <= 1'b0;
    end else if (tick_in) begin
      pre_ff <= wrap ? 4'h0 : pre_ff + 4'h1;
      if (wrap) begin
        cnt_ff <= last ? 8'h00 : cnt_ff + 8'h01;
        irq_out <= last;
      end
    end
  end
endmodule // icp_companion

// File: tb/icp_timer_tb.sv
`timescale 1ns/1ps
`include "icp_map.svh"

module icp_timer_tb;
  `define CHK(g, w) \
    begin n_tests++; if ((g) !== (w)) begin failures++; \
    $display("Error at %0t: got %0h want %0h", $time, g, w); end end
  logic mclk, rst_n, psel, penable, pwrite, tick, cirq, cen;
  logic out, irq, pready, perr, err;
  logic [1:0] div;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int failures, n_tests, cyc, n;

  icp_timer u_dut (
    .mclk_in(mclk), .nrst_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .count_tick_in(tick), .companion_irq_in(cirq),
    .timer_output_out(out), .timer_match_irq_out(irq)
  );
  icp_companion u_comp (
    .mclk_in(mclk), .nrst_in(rst_n), .tick_in(tick),
    .enable_in(cen), .irq_out(cirq)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ------------------------------
  // count ticks and watchdog
  // ------------------------------
  always @(posedge mclk) begin
    div <= div + 2'h1;
    tick <= (div == 2'h3);
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(negedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic until_out(input logic v, output int k);
    k = 0;
    @(negedge mclk);
    while (out !== v) begin
      if (tick === 1'b1) k++;
      @(negedge mclk);
    end
  endtask

  task automatic sync_tick();
    do @(negedge mclk); while (tick !== 1'b1);
    @(negedge mclk);
  endtask

  task automatic wait_strobe();
    do @(negedge mclk); while (cirq !== 1'b0);
    do @(negedge mclk); while (cirq !== 1'b1);
    repeat (64) @(negedge mclk);
  endtask

  task automatic hold(input logic v);
    int k;
    k = 0;
    repeat (160) begin
      @(negedge mclk);
      if (out !== v) k++;
    end
    `CHK(k, 0)
  endtask

  task automatic t_regs();
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 12'(a), 32'h0000_0000);
      `CHK(rd, `ICP_RST_WORD)
    end
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
    apb(1'b1, `ICP_OFF_CTRL, 32'h0000_0018);
    apb(1'b0, `ICP_OFF_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0008)
    $display("test regs done");
  endtask

  task automatic t_pwm();
    // compares set while stopped, duty below cycle
    apb(1'b1, `ICP_OFF_CMP0, 32'h0000_0005);
    apb(1'b1, `ICP_OFF_CMP1, 32'h0000_0002);
    sync_tick();
    apb(1'b1, `ICP_OFF_CTRL, 32'h0000_0001);
    until_out(1'b1, n);
    `CHK(n, 7)
    `CHK(irq, 1'b1)
    until_out(1'b0, n);
    `CHK(n, 3)
    until_out(1'b1, n);
    `CHK(n, 3)
    apb(1'b1, `ICP_OFF_CMP1, 32'h0000_0003);
    apb(1'b0, `ICP_OFF_CMP1, 32'h0000_0000);
    `CHK(rd, 32'h0000_0003)
    // write is too young at the next duty match: old width kept
    until_out(1'b0, n);
    `CHK(n, 1)
    // transfer happens at the old-value match, which still ends low
    until_out(1'b1, n);
    until_out(1'b0, n);
    `CHK(n, 3)
    until_out(1'b1, n);
    until_out(1'b0, n);
    `CHK(n, 4)
    until_out(1'b1, n);
    // stop while the output is active
    apb(1'b1, `ICP_OFF_CTRL, 32'h0000_0000);
    apb(1'b0, `ICP_OFF_STAT, 32'h0000_0000);
    `CHK({rd[10], rd[7:0], irq}, 10'h000)
    $display("test pwm done");
  endtask

  task automatic t_carrier();
    // low width 2, high width 3
    apb(1'b1, `ICP_OFF_CMP0, 32'h0000_0002);
    apb(1'b1, `ICP_OFF_CMP1, 32'h0000_0003);
    // remote set first, companion started last
    apb(1'b1, `ICP_OFF_CTRL, 32'h0000_000E);
    apb(1'b1, `ICP_OFF_CTRL, 32'h0000_000F);
    cen <= 1'b1;
    apb(1'b0, `ICP_OFF_CTRL, 32'h0000_0000);
    `CHK({rd[4], out}, 2'b00)
    until_out(1'b1, n);
    apb(1'b0, `ICP_OFF_CTRL, 32'h0000_0000);
    `CHK(rd[4], 1'b1)
    until_out(1'b0, n);
    until_out(1'b1, n);
    `CHK(n, 3)
    until_out(1'b0, n);
    `CHK(n, 4)
    // only the buffered bit is rewritten
    apb(1'b1, `ICP_OFF_CTRL, 32'h0000_0007);
    wait_strobe();
    hold(1'b0);
    apb(1'b1, `ICP_OFF_CTRL, 32'h0000_0000);
    cen <= 1'b0;
    // steady level with remote output off
    apb(1'b1, `ICP_OFF_CMP1, 32'h0000_0003);
    apb(1'b1, `ICP_OFF_CTRL, 32'h0000_000B);
    cen <= 1'b1;
    wait_strobe();
    hold(1'b1);
    apb(1'b1, `ICP_OFF_CTRL, 32'h0000_0000);
    cen <= 1'b0;
    apb(1'b0, `ICP_OFF_STAT, 32'h0000_0000);
    `CHK({rd[10], out}, 2'b00)
    $display("test carrier done");
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, tick, cen, div} = '0;
    {paddr, pwdata, failures, n_tests, cyc} = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_pwm();
    t_carrier();
    close_out();
  end
endmodule // icp_timer_tb
